/* rtl/sbsa_pkg.sv */
// Shared constants and types for the synchronous burst SRAM access block
package sbsa_pkg;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int ADDR_W     = 18;
  localparam int LANE_W     = 9;
  localparam int LANES      = 4;
  localparam int DATA_W     = LANE_W * LANES;
  localparam int WORDS      = 1 << ADDR_W;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = ADDR_W + LANES + DATA_W;

  // ****************************************************************
  // Field positions inside a queued write entry
  // ****************************************************************
  localparam int ENT_DATA_LSB = 0;
  localparam int ENT_MASK_LSB = DATA_W;
  localparam int ENT_ADDR_LSB = DATA_W + LANES;

  // ****************************************************************
  // Burst and sleep timing
  // ****************************************************************
  localparam logic [1:0] BURST_STEP_RST  = 2'h0;
  localparam logic [1:0] BURST_STEP_ONE  = 2'h1;
  localparam logic [3:0] ALL_LANES       = 4'hF;
  localparam logic [3:0] NO_LANES        = 4'h0;
  localparam int         CLK_PERIOD_NS   = 100;
  localparam int         SLEEP_ENTER_CYC = 2;
  localparam int         SLEEP_EXIT_CYC  = 2;
  localparam logic [1:0] SLEEP_ENTER_LAST = 2'(SLEEP_ENTER_CYC - 1);
  localparam logic [1:0] SLEEP_EXIT_LAST  = 2'(SLEEP_EXIT_CYC - 1);
  localparam logic [1:0] SLEEP_CNT_RST    = 2'h0;

  // ****************************************************************
  // Sleep sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    SBSA_AWAKE    = 4'h1,
    SBSA_ENTERING = 4'h2,
    SBSA_ASLEEP   = 4'h4,
    SBSA_EXITING  = 4'h8
  } sbsa_sleep_e;

endpackage : sbsa_pkg

/* rtl/sbsa_top.sv */
// Synchronous flow-through burst SRAM access logic with write queue and array
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Register all synchronous inputs on rising clock
// - Burst order pin: low linear, high interleaved
// - Load address bits 1:0 into burst counter
// - Interleaved order: start address XOR step
// - Linear order: start plus step, modulo four
// - Only advance input steps the burst counter
// - Processor strobe ignored while primary select high
// - Start read when selected and strobe low
// - Latch start address, drive read data
// - Processor start ignores writes in first cycle
// - Controller strobe with write inputs writes immediately
// - Processor strobe overrides controller strobe
// - Data pins released whenever a write occurs
// - Byte lanes gated; global write sets all
// - Writes complete internally, self-timed
// - Sleep entry and exit take two cycles
// - Accesses pending at sleep are lost; the code drops the open burst but keeps queued writes, which commit after wake
// - Write when global low or gated lane low
// - Idle strobes: advance low steps, high suspends
// - Read drives data only when enabled, selected

// ******************************************************************
// Write queue
// ******************************************************************
module sbsa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] slots [DEPTH];
  logic [PW-1:0]    wrPtr_reg;
  logic [PW-1:0]    rdPtr_reg;
  logic [PW:0]      count_reg;
  wire              push;
  wire              pop;

  assign inReady  = count_reg != (PW+1)'(DEPTH);
  assign outValid = count_reg != '0;
  assign outData  = slots[rdPtr_reg];
  assign push     = clkEn & inValid & inReady;
  assign pop      = clkEn & outValid & outReady;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wrPtr_reg <= wrPtr_reg + PW'(1);
      if (pop) rdPtr_reg <= rdPtr_reg + PW'(1);
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) slots[wrPtr_reg] <= inData;
  end
endmodule : sbsa_fifo

// ******************************************************************
// Access control
// ******************************************************************
module sbsa_top (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       clkEn,
  input  wire logic [sbsa_pkg::ADDR_W-1:0] addrIn,
  input  wire logic [sbsa_pkg::DATA_W-1:0] dqIn,
  output logic      [sbsa_pkg::DATA_W-1:0] dqOut,
  output logic                            dqOe,
  input  wire logic                       chip_select_primary_n,
  input  wire logic                       chip_select_expand_hi,
  input  wire logic                       chip_select_expand_lo_n,
  input  wire logic                       processor_addr_strobe_n,
  input  wire logic                       controller_addr_strobe_n,
  input  wire logic                       burst_advance_n,
  input  wire logic                       byte_lane_write_gate_n,
  input  wire logic [sbsa_pkg::LANES-1:0] byte_lane_select_n,
  input  wire logic                       all_lanes_write_n,
  input  wire logic                       outEnable_n,
  input  wire logic                       burstOrderSel,
  input  wire logic                       sleep_request,
  output logic                            sleepActive,
  output logic                            writeStall
);
  import sbsa_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [DATA_W-1:0]      mem [WORDS];
  logic [ADDR_W-3:0]      base_reg;
  logic [1:0]             startLow_reg;
  logic [1:0]             step_reg;
  logic                   order_reg;
  logic                   burstActive_reg;
  logic [ADDR_W-1:0]      curAddr_reg;
  logic [DATA_W-1:0]      dqOut_reg;
  logic                   dqOe_reg;
  logic                   sleepActive_reg;
  logic                   writeStall_reg;
  sbsa_sleep_e            sleep_reg;
  sbsa_sleep_e            sleep_next;
  logic [1:0]             sleepCnt_reg;
  logic [1:0]             sleepCnt_next;

  // ****************************************************************
  // Cycle decode
  // ****************************************************************
  wire awake     = sleep_reg == SBSA_AWAKE;
  wire cs1On     = ~chip_select_primary_n;
  wire selAll    = cs1On & chip_select_expand_hi & ~chip_select_expand_lo_n;
  wire procSeen  = ~processor_addr_strobe_n & cs1On;
  wire ctrlSeen  = ~controller_addr_strobe_n & ~procSeen;
  wire strobeAny = procSeen | ctrlSeen;
  wire startAny  = strobeAny & selAll;
  wire deselect  = strobeAny & ~selAll;
  wire contCycle = ~strobeAny & burstActive_reg;
  wire advance   = contCycle & ~burst_advance_n;

  // Write qualification: global write overrides the lane gate
  wire writeSeen = ~all_lanes_write_n | (~byte_lane_write_gate_n & ~&byte_lane_select_n);
  wire [LANES-1:0] laneMask = ~all_lanes_write_n ? ALL_LANES :
                              (byte_lane_write_gate_n ? NO_LANES : ~byte_lane_select_n);

  // A processor-strobe start is always a read; write inputs wait a cycle
  wire startWrite = startAny & ctrlSeen & writeSeen;
  wire startRead  = startAny & ~startWrite;

  // ****************************************************************
  // Burst counter
  // ****************************************************************
  wire [1:0]        stepNext     = startAny ? BURST_STEP_RST :
                                   (advance ? step_reg + BURST_STEP_ONE : step_reg);
  wire [1:0]        startLowNext = startAny ? addrIn[1:0] : startLow_reg;
  wire [ADDR_W-3:0] baseNext     = startAny ? addrIn[ADDR_W-1:2] : base_reg;
  wire              orderNext    = startAny ? burstOrderSel : order_reg;
  wire [1:0]        lowInter     = startLowNext ^ stepNext;
  wire [1:0]        lowLinear    = startLowNext + stepNext;
  wire [1:0]        lowNext      = orderNext ? lowInter : lowLinear;
  wire [ADDR_W-1:0] cycleAddr    = {baseNext, lowNext};

  // The open burst is dropped as soon as the sleep sequence starts
  wire burstNext  = awake & ~sleep_request & (startAny | (burstActive_reg & ~deselect));
  wire cycleWrite = awake & (startWrite | (contCycle & writeSeen));
  wire cycleRead  = awake & (startRead | (contCycle & ~writeSeen));

  // ****************************************************************
  // Write queue toward the array
  // ****************************************************************
  wire [FIFO_W-1:0] qIn = {cycleAddr, laneMask, dqIn};
  wire [FIFO_W-1:0] qOut;
  wire              qInReady;
  wire              qOutValid;
  // Draining pauses outside the awake state, where no writes are queued either
  wire              qOutReady = awake;
  wire              qPop      = clkEn & qOutValid & qOutReady;
  wire [ADDR_W-1:0] qAddr     = qOut[ENT_ADDR_LSB +: ADDR_W];
  wire [LANES-1:0]  qMask     = qOut[ENT_MASK_LSB +: LANES];
  wire [DATA_W-1:0] qData     = qOut[ENT_DATA_LSB +: DATA_W];

  sbsa_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) uWriteQueue (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clkEn    (clkEn),
    .inData   (qIn),
    .inValid  (cycleWrite),
    .inReady  (qInReady),
    .outData  (qOut),
    .outValid (qOutValid),
    .outReady (qOutReady)
  );

  // Self-timed commit: one queued entry per cycle, lane by lane
  always_ff @(posedge clk_sys) begin
    if (qPop) begin
      for (int l = 0; l < LANES; l++) begin
        if (qMask[l]) mem[qAddr][l*LANE_W +: LANE_W] <= qData[l*LANE_W +: LANE_W];
      end
    end
  end

  // ****************************************************************
  // Sleep sequencer
  // ****************************************************************
  always_comb begin
    sleep_next    = sleep_reg;
    sleepCnt_next = sleepCnt_reg;
    case (sleep_reg)
      SBSA_AWAKE: begin
        if (sleep_request) begin
          sleep_next    = SBSA_ENTERING;
          sleepCnt_next = SLEEP_CNT_RST;
        end
      end
      SBSA_ENTERING: begin
        sleepCnt_next = sleepCnt_reg + 2'h1;
        if (sleepCnt_reg == SLEEP_ENTER_LAST) begin
          sleep_next    = SBSA_ASLEEP;
          sleepCnt_next = SLEEP_CNT_RST;
        end
      end
      SBSA_ASLEEP: begin
        if (!sleep_request) sleep_next = SBSA_EXITING;
      end
      SBSA_EXITING: begin
        sleepCnt_next = sleepCnt_reg + 2'h1;
        if (sleep_request) begin
          sleep_next    = SBSA_ENTERING;
          sleepCnt_next = SLEEP_CNT_RST;
        end else if (sleepCnt_reg == SLEEP_EXIT_LAST) begin
          sleep_next    = SBSA_AWAKE;
          sleepCnt_next = SLEEP_CNT_RST;
        end
      end
      default: begin
        sleep_next    = SBSA_AWAKE;
        sleepCnt_next = SLEEP_CNT_RST;
      end
    endcase
  end

  // ****************************************************************
  // Input registers and outputs
  // ****************************************************************
  // Output enable is sampled with the clock, so release lags it by one edge
  wire              dqOeNext  = cycleRead & ~outEnable_n;
  wire [DATA_W-1:0] dqOutNext = mem[cycleAddr];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleep_reg    <= SBSA_AWAKE;
      sleepCnt_reg <= SLEEP_CNT_RST;
    end else if (clkEn) begin
      sleep_reg    <= sleep_next;
      sleepCnt_reg <= sleepCnt_next;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      base_reg        <= '0;
      startLow_reg    <= BURST_STEP_RST;
      step_reg        <= BURST_STEP_RST;
      order_reg       <= 1'b1;
      burstActive_reg <= 1'b0;
      curAddr_reg     <= '0;
    end else if (clkEn) begin
      base_reg        <= baseNext;
      startLow_reg    <= startLowNext;
      step_reg        <= stepNext;
      order_reg       <= orderNext;
      burstActive_reg <= burstNext;
      curAddr_reg     <= cycleAddr;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dqOut_reg       <= '0;
      dqOe_reg        <= 1'b0;
      sleepActive_reg <= 1'b0;
      writeStall_reg  <= 1'b0;
    end else if (clkEn) begin
      dqOut_reg       <= dqOutNext;
      dqOe_reg        <= dqOeNext;
      sleepActive_reg <= sleep_next != SBSA_AWAKE;
      writeStall_reg  <= ~qInReady;
    end
  end

  assign dqOut       = dqOut_reg;
  assign dqOe        = dqOe_reg;
  assign sleepActive = sleepActive_reg;
  assign writeStall  = writeStall_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_write_releases_dq: assert property (clkEn && cycleWrite |=> !dqOe)
    else $error("data pins driven during a write cycle");
  a_read_drives_dq: assert property (clkEn && cycleRead && !outEnable_n |=> dqOe)
    else $error("enabled read did not drive data pins");
  a_proc_strobe_masked: assert property (clkEn && chip_select_primary_n && controller_addr_strobe_n
                                         && !burstActive_reg |=> !burstActive_reg)
    else $error("processor strobe accepted with primary select high");
  a_proc_start_read: assert property (clkEn && awake && procSeen && selAll |-> cycleRead && !cycleWrite)
    else $error("processor strobe start did not give a read");
  a_ctrl_start_write: assert property (clkEn && awake && !processor_addr_strobe_n == 1'b0
                                        && !controller_addr_strobe_n && selAll && writeSeen
                                        |-> cycleWrite && cycleAddr == addrIn)
    else $error("controller strobe write not performed at loaded address");
  a_proc_priority: assert property (clkEn && awake && procSeen && selAll && !controller_addr_strobe_n
                                     |=> step_reg == BURST_STEP_RST && dqOe == !$past(outEnable_n))
    else $error("controller strobe not overridden by processor strobe");
  a_start_loads_ctr: assert property (clkEn && startAny |=> startLow_reg == $past(addrIn[1:0])
                                       && step_reg == BURST_STEP_RST)
    else $error("burst counter not loaded at start");
  a_advance_steps: assert property (clkEn && contCycle && !burst_advance_n
                                     |=> step_reg == $past(step_reg) + 2'h1)
    else $error("burst counter did not step on advance");
  a_suspend_holds: assert property (clkEn && contCycle && burst_advance_n
                                     |=> curAddr_reg == $past(curAddr_reg))
    else $error("suspended burst changed address");
  a_interleave_seq: assert property (clkEn && contCycle && order_reg && !burst_advance_n
                                      && step_reg == 2'h1 |=> curAddr_reg[1:0] == (startLow_reg ^ 2'h2))
    else $error("interleaved burst address wrong");
  a_linear_seq: assert property (clkEn && contCycle && !order_reg && !burst_advance_n
                                  && step_reg == 2'h2 |=> curAddr_reg[1:0] == startLow_reg + 2'h3)
    else $error("linear burst address wrong");
  a_sleep_entry: assert property (clkEn && awake && sleep_request ##1 clkEn ##1 clkEn
                                   |=> sleep_reg == SBSA_ASLEEP)
    else $error("sleep not entered after two cycles");
  a_sleep_drops: assert property (clkEn && !awake |=> !burstActive_reg && !dqOe)
    else $error("access survived sleep entry");

  c_read_burst: cover property (clkEn && startRead && awake ##1 (clkEn && advance)[*3]);
  c_ctrl_write: cover property (clkEn && awake && startWrite);
  c_queue_full: cover property (clkEn && !qInReady);
  c_sleep_cycle: cover property (sleep_reg == SBSA_ASLEEP ##[1:20] sleep_reg == SBSA_AWAKE);
endmodule : sbsa_top
`default_nettype wire

/* verification/sbsa_host_model.sv */
// Host model that drives the burst SRAM access pins
`timescale 1ns/1ps
`default_nettype none
module sbsa_host_model (
  input  wire logic                        clk_sys,
  output logic [sbsa_pkg::ADDR_W-1:0]      addrIn,
  output logic [sbsa_pkg::DATA_W-1:0]      dqIn,
  output logic                             chip_select_primary_n,
  output logic                             chip_select_expand_hi,
  output logic                             chip_select_expand_lo_n,
  output logic                             processor_addr_strobe_n,
  output logic                             controller_addr_strobe_n,
  output logic                             burst_advance_n,
  output logic                             byte_lane_write_gate_n,
  output logic [sbsa_pkg::LANES-1:0]       byte_lane_select_n,
  output logic                             all_lanes_write_n,
  output logic                             outEnable_n,
  output logic                             sleep_request
);
  import sbsa_pkg::*;

  initial begin
    {chip_select_primary_n, chip_select_expand_hi, chip_select_expand_lo_n} = 3'h5;
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
    {all_lanes_write_n, byte_lane_write_gate_n, byte_lane_select_n, outEnable_n} = 7'h7F;
    addrIn = '0;
    dqIn = '0;
    sleep_request = 1'b0;
  end

  // ****************************************************************
  // One bus cycle, presented at a rising edge
  // ****************************************************************
  task automatic step(input logic [2:0] sel, input logic [1:0] strb, input logic advN, input logic gwN,
                      input logic gateN, input logic [3:0] lnN, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic oeN);
    @(posedge clk_sys);
    {chip_select_primary_n, chip_select_expand_hi, chip_select_expand_lo_n} <= sel;
    {processor_addr_strobe_n, controller_addr_strobe_n} <= strb;
    burst_advance_n <= advN;
    all_lanes_write_n <= gwN;
    byte_lane_write_gate_n <= gateN;
    byte_lane_select_n <= lnN;
    addrIn <= a;
    // Released data lines toggle so a stale word never passes for write data
    dqIn <= (!gwN || !gateN) ? d : ~dqIn;
    outEnable_n <= oeN;
    @(negedge clk_sys);
  endtask : step

  task automatic idle();
    step(3'h5, 2'h3, 1'b1, 1'b1, 1'b1, 4'hF, '0, '0, 1'b1);
  endtask : idle

  // ****************************************************************
  // Sleep request, always with the device deselected
  // ****************************************************************
  task automatic nap(input logic v);
    @(posedge clk_sys);
    chip_select_primary_n <= 1'b1;
    {processor_addr_strobe_n, controller_addr_strobe_n} <= 2'h3;
    sleep_request <= v;
    @(negedge clk_sys);
  endtask : nap
endmodule : sbsa_host_model
`default_nettype wire

/* verification/sync_burst_sram_access_tb.sv */
// Self-checking bench for the burst SRAM access block
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_access_tb;
  import sbsa_pkg::*;
  localparam logic [2:0]        SEL = 3'h2;
  localparam logic [2:0]        DES = 3'h5;
  localparam logic [1:0]        PS  = 2'h1;
  localparam logic [1:0]        CS  = 2'h2;
  localparam logic [1:0]        NS  = 2'h3;
  localparam logic [ADDR_W-1:0] B   = 18'h00100;
  localparam logic [DATA_W-1:0] M   = 36'h007FC01FF;
  logic              clk_sys, rst, clkEn, dqOe, burstOrderSel, sleepActive, writeStall;
  logic [ADDR_W-1:0] addrIn;
  logic [DATA_W-1:0] dqIn, dqOut;
  logic              chip_select_primary_n, chip_select_expand_hi, chip_select_expand_lo_n;
  logic              processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
  logic              byte_lane_write_gate_n, all_lanes_write_n, outEnable_n, sleep_request;
  logic [LANES-1:0]  byte_lane_select_n;
  int                miscompares, checkCount, cycles;

  sbsa_top dut (.clk_sys, .rst, .clkEn, .addrIn, .dqIn, .dqOut, .dqOe, .chip_select_primary_n,
    .chip_select_expand_hi, .chip_select_expand_lo_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
    .burst_advance_n, .byte_lane_write_gate_n, .byte_lane_select_n, .all_lanes_write_n, .outEnable_n,
    .burstOrderSel, .sleep_request, .sleepActive, .writeStall);
  sbsa_host_model host (.clk_sys, .addrIn, .dqIn, .chip_select_primary_n, .chip_select_expand_hi,
    .chip_select_expand_lo_n, .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
    .byte_lane_write_gate_n, .byte_lane_select_n, .all_lanes_write_n, .outEnable_n, .sleep_request);

  always #50 clk_sys = ~clk_sys;

  // About 110 cycles are needed; the ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
    return {a, a} ^ 36'hA5A5A5A5A;
  endfunction : pat

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [ADDR_W-1:0] a);
    host.step(SEL, PS, 1'b1, 1'b1, 1'b1, 4'hF, a, '0, 1'b0);
  endtask : rd

  task automatic nx(input logic advN);
    host.step(DES, NS, advN, 1'b1, 1'b1, 4'hF, '1, '0, 1'b0);
  endtask : nx

  // ****************************************************************
  // Scenarios; read data shows after the following bus cycle
  // ****************************************************************
  task automatic t_write();
    for (int i = 0; i < 3; i++)
      host.step(SEL, CS, 1'b1, 1'b0, 1'b1, 4'hF, B + 18'(i), pat(B + 18'(i)), 1'b1);
    host.step(SEL, CS, 1'b1, 1'b0, 1'b1, 4'hF, B + 18'h3, pat(B + 18'h3), 1'b0);
    host.idle();
    chk("write dqOe", 1'b0, dqOe);
    chk("writeStall", 1'b0, writeStall);
    host.idle();
    rd(B);
    for (int i = 1; i < 4; i++) begin
      rd(B + 18'(i));
      chk("read dqOut", pat(B + 18'(i - 1)), dqOut);
      chk("read dqOe", 1'b1, dqOe);
    end
    host.idle();
    chk("read dqOut", pat(B + 18'h3), dqOut);
    $display("test write and read done");
  endtask : t_write

  task automatic t_burst(input logic ord, input logic [1:0] s);
    logic [1:0] st;
    logic [1:0] lo;
    @(posedge clk_sys);
    burstOrderSel <= ord;
    rd(B | 18'(s));
    for (int k = 0; k < 5; k++) begin
      if (k < 4)
        nx(k == 1);
      else
        host.idle();
      st = (k < 2) ? 2'(k) : 2'(k - 1);
      lo = ord ? s ^ st : s + st;
      chk("burst dqOut", pat(B | 18'(lo)), dqOut);
    end
    $display("test burst order %0d start %0d done", ord, s);
  endtask : t_burst

  // Advance stays low while the enable is low, so a leaky freeze moves the burst on
  task automatic t_freeze();
    rd(B);
    nx(1'b0);
    @(posedge clk_sys);
    clkEn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("frozen dqOut", pat(B + 18'h1), dqOut);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    host.idle();
    chk("resumed dqOut", pat(B + 18'h2), dqOut);
    $display("test clock enable done");
  endtask : t_freeze

  task automatic t_proc();
    host.step(SEL, PS, 1'b1, 1'b0, 1'b1, 4'hF, B + 18'h1, '0, 1'b0);
    host.step(DES, NS, 1'b1, 1'b0, 1'b1, 4'hF, '1, 36'h123456789, 1'b1);
    chk("proc start dqOut", pat(B + 18'h1), dqOut);
    chk("proc start dqOe", 1'b1, dqOe);
    host.step(SEL, 2'h0, 1'b1, 1'b0, 1'b1, 4'hF, B + 18'h2, 36'hFEDCBA987, 1'b0);
    chk("suspend write dqOe", 1'b0, dqOe);
    host.idle();
    chk("both strobes dqOut", pat(B + 18'h2), dqOut);
    host.idle();
    rd(B + 18'h1);
    rd(B + 18'h2);
    chk("proc write data", 36'h123456789, dqOut);
    host.idle();
    chk("both strobes no write", pat(B + 18'h2), dqOut);
    $display("test processor strobe done");
  endtask : t_proc

  task automatic t_bytes();
    host.step(SEL, CS, 1'b1, 1'b1, 1'b0, 4'hA, B + 18'h3, 36'h0F0F0F0F0, 1'b1);
    host.step(SEL, CS, 1'b1, 1'b1, 1'b1, 4'h0, B, '0, 1'b0);
    chk("lane write dqOe", 1'b0, dqOe);
    host.step(SEL, CS, 1'b1, 1'b0, 1'b0, 4'hE, B + 18'h2, 36'h5A5A5A5A5, 1'b1);
    chk("gate off dqOut", pat(B), dqOut);
    chk("gate off dqOe", 1'b1, dqOe);
    host.idle();
    host.idle();
    rd(B + 18'h3);
    rd(B + 18'h2);
    chk("lane merge", (36'h0F0F0F0F0 & M) | (pat(B + 18'h3) & ~M), dqOut);
    host.idle();
    chk("global write", 36'h5A5A5A5A5, dqOut);
    $display("test byte lanes done");
  endtask : t_bytes

  task automatic t_desel();
    rd(B);
    host.step(3'h6, PS, 1'b1, 1'b1, 1'b1, 4'hF, B + 18'h2, '0, 1'b0);
    host.step(SEL, PS, 1'b1, 1'b1, 1'b1, 4'hF, B + 18'h2, '0, 1'b1);
    chk("ignored strobe dqOut", pat(B), dqOut);
    chk("ignored strobe dqOe", 1'b1, dqOe);
    host.step(3'h0, CS, 1'b1, 1'b1, 1'b1, 4'hF, B + 18'h2, '0, 1'b0);
    chk("disabled dqOe", 1'b0, dqOe);
    host.idle();
    chk("deselected dqOe", 1'b0, dqOe);
    $display("test deselect done");
  endtask : t_desel

  task automatic t_sleep();
    int n;
    host.nap(1'b1);
    host.nap(1'b1);
    chk("sleep entered", 1'b1, sleepActive);
    host.nap(1'b1);
    host.nap(1'b0);
    n = 0;
    do begin
      host.idle();
      n++;
    end while (sleepActive === 1'b1 && n < 8);
    chk("wake edges", 36'h3, 36'(n));
    host.idle();
    host.idle();
    rd(B);
    host.idle();
    chk("kept data", pat(B), dqOut);
    $display("test sleep done");
  endtask : t_sleep

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    clkEn = 1'b1;
    burstOrderSel = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("reset dqOe", 1'b0, dqOe);
    chk("reset sleepActive", 1'b0, sleepActive);
    chk("reset writeStall", 1'b0, writeStall);
    t_write();
    for (int o = 0; o < 2; o++)
      for (int s = 0; s < 4; s++)
        t_burst(1'(o), 2'(s));
    t_freeze();
    t_proc();
    t_bytes();
    t_desel();
    t_sleep();
    end_of_test();
  end
endmodule : sync_burst_sram_access_tb
`default_nettype wire
